// file: pkg/ois_pkg.sv
`default_nettype none
package ois_pkg;
  // Panel geometry
  localparam int OIS_COL_W = 7;
  localparam int OIS_PAGE_W = 3;
  localparam int OIS_RAM_AW = OIS_COL_W + OIS_PAGE_W;
  localparam int OIS_RAM_DEPTH = 1 << OIS_RAM_AW;
  localparam logic [6:0] OIS_COL_LAST = 7'h7F;
  localparam logic [2:0] OIS_PAGE_LAST = 3'h7;

  // Command bytes
  localparam logic [7:0] OIS_CMD_DISP_OFF = 8'hAE;
  localparam logic [7:0] OIS_CMD_DISP_ON = 8'hAF;
  localparam logic [7:0] OIS_CMD_SHOW_RAM = 8'hA4;
  localparam logic [7:0] OIS_CMD_ALL_ON = 8'hA5;
  localparam logic [7:0] OIS_CMD_POL_NORM = 8'hA6;
  localparam logic [7:0] OIS_CMD_POL_INV = 8'hA7;
  localparam logic [7:0] OIS_CMD_SEG_NORM = 8'hA0;
  localparam logic [7:0] OIS_CMD_SEG_REMAP = 8'hA1;
  localparam logic [7:0] OIS_CMD_SCAN_NORM = 8'hC0;
  localparam logic [7:0] OIS_CMD_SCAN_REV = 8'hC8;
  localparam logic [7:0] OIS_CMD_ADDR_MODE = 8'h20;
  localparam logic [7:0] OIS_CMD_CONTRAST = 8'h81;
  localparam logic [7:0] OIS_CMD_MUX = 8'hA8;
  localparam logic [7:0] OIS_CMD_OFFSET = 8'hD3;
  localparam logic [7:0] OIS_CMD_CLK_DIV = 8'hD5;
  localparam logic [7:0] OIS_CMD_PRECHG = 8'hD9;
  localparam logic [7:0] OIS_CMD_COM_CFG = 8'hDA;
  localparam logic [7:0] OIS_CMD_VCOMH = 8'hDB;
  localparam logic [7:0] OIS_CMD_PUMP = 8'h8D;
  // Range commands: upper bits select the group
  localparam logic [1:0] OIS_GRP_START_LINE = 2'h1;
  localparam logic [3:0] OIS_GRP_COL_LO = 4'h0;
  localparam logic [3:0] OIS_GRP_COL_HI = 4'h1;
  localparam logic [4:0] OIS_GRP_PAGE = 5'h16;

  // Addressing modes
  localparam logic [1:0] OIS_MODE_HORZ = 2'h0;
  localparam logic [1:0] OIS_MODE_VERT = 2'h1;
  localparam logic [1:0] OIS_MODE_PAGE = 2'h2;

  // Reset values
  localparam logic [7:0] OIS_CONTRAST_RST = 8'h7F;
  localparam logic [5:0] OIS_MUX_RST = 6'h3F;
  localparam logic [5:0] OIS_START_RST = 6'h00;
  localparam logic [6:0] OIS_COL_RST = 7'h00;
  localparam logic [2:0] OIS_PAGE_RST = 3'h0;
  localparam logic [5:0] OIS_OFFSET_RST = 6'h00;
  localparam logic [1:0] OIS_MODE_RST = OIS_MODE_PAGE;
  localparam logic [7:0] OIS_CLK_DIV_RST = 8'h80;
  localparam logic [7:0] OIS_PRECHG_RST = 8'h22;
  localparam logic [7:0] OIS_COM_CFG_RST = 8'h12;
  localparam logic [7:0] OIS_VCOMH_RST = 8'h20;
  localparam logic [7:0] OIS_PUMP_RST = 8'h10;
  localparam logic [2:0] OIS_BIT_LAST = 3'h7;
endpackage
`default_nettype wire

// file: design/ois_frame_ram.sv
`default_nettype none
module ois_frame_ram
  import ois_pkg::*;
(
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [OIS_RAM_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [OIS_RAM_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [OIS_RAM_DEPTH];

  // Display memory content is not cleared by reset, as on the panel
  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// file: design/ois_sequencer.sv
`default_nettype none
// Notes on behaviour
// - Reset turns the display off and selects the 128x64 mode.
// - Reset restores normal segment and common mapping to address zero.
// - Reset clears the serial shift register; partial bits are lost.
// - Reset sets display start line to memory address zero.
// - Reset loads the column address counter with zero.
// - Reset selects normal common output scan direction.
// - Reset loads contrast with 7Fh.
// - After reset the display shows memory contents, as after A4h.
// - Command AEh turns the display off, AFh turns it on.
// - A4h shows memory contents, A5h forces every pixel on.
// - A6h selects normal polarity, A7h inverted polarity.
// - 20h then 02h selects page addressing for memory writes.
// - DAh plus a parameter sets common pin configuration; host sends 12h.
// - D5h plus a parameter sets clock divide; host sends 80h.
// - DBh plus a parameter sets common deselect level; 30h is 0.83.
// - Data/command line high marks data, low marks a command.
module ois_sequencer
  import ois_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic dc_select_line,
  input wire logic [OIS_RAM_AW-1:0] rd_addr,
  output logic [7:0] rd_data,
  output logic display_on_q,
  output logic entire_on_q,
  output logic invert_q,
  output logic seg_remap_q,
  output logic com_scan_rev_q,
  output logic [5:0] start_line_q,
  output logic [7:0] contrast_q,
  output logic [5:0] mux_ratio_q,
  output logic [5:0] disp_offset_q,
  output logic [1:0] addr_mode_q,
  output logic [7:0] clk_div_q,
  output logic [7:0] precharge_q,
  output logic [7:0] com_cfg_q,
  output logic [7:0] vcomh_q,
  output logic [7:0] pump_cfg_q,
  output logic [6:0] col_addr_q,
  output logic [2:0] page_addr_q
);
  typedef enum logic [0:0] {OIS_ST_CMD, OIS_ST_PARAM} ois_state_t;

  function automatic logic ois_has_param(input logic [7:0] cmd);
    ois_has_param = (cmd == OIS_CMD_ADDR_MODE) || (cmd == OIS_CMD_CONTRAST) ||
                    (cmd == OIS_CMD_MUX) || (cmd == OIS_CMD_OFFSET) ||
                    (cmd == OIS_CMD_CLK_DIV) || (cmd == OIS_CMD_PRECHG) ||
                    (cmd == OIS_CMD_COM_CFG) || (cmd == OIS_CMD_VCOMH) ||
                    (cmd == OIS_CMD_PUMP);
  endfunction

  // Serial receive group
  logic sclk_q, sclk_d;
  logic [6:0] shift_q, shift_d;
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic byte_vld_q, byte_vld_d;
  logic [7:0] byte_q, byte_d;
  logic is_data_q, is_data_d;

  always_comb
  begin
    sclk_d = sclk;
    shift_d = shift_q;
    bit_cnt_d = bit_cnt_q;
    byte_vld_d = 1'b0;
    byte_d = byte_q;
    is_data_d = is_data_q;
    if (cs_n)
    begin
      shift_d = '0;
      bit_cnt_d = '0;
    end
    else if (sclk && !sclk_q)
    begin
      shift_d = {shift_q[5:0], serial_data_in};
      bit_cnt_d = bit_cnt_q + 3'h1;
      if (bit_cnt_q == OIS_BIT_LAST)
      begin
        byte_vld_d = 1'b1;
        byte_d = {shift_q, serial_data_in};
        is_data_d = dc_select_line;
        shift_d = '0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_q <= 1'b0;
      shift_q <= '0;
      bit_cnt_q <= '0;
      byte_vld_q <= 1'b0;
      byte_q <= '0;
      is_data_q <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk_d;
      shift_q <= shift_d;
      bit_cnt_q <= bit_cnt_d;
      byte_vld_q <= byte_vld_d;
      byte_q <= byte_d;
      is_data_q <= is_data_d;
    end
  end

  // Command interpreter group
  ois_state_t state_q, state_d;
  logic [7:0] pend_q, pend_d;
  logic display_on_d, entire_on_d, invert_d, seg_remap_d, com_scan_rev_d;
  logic [5:0] start_line_d, mux_ratio_d, disp_offset_d;
  logic [7:0] contrast_d, clk_div_d, precharge_d, com_cfg_d, vcomh_d, pump_cfg_d;
  logic [1:0] addr_mode_d;
  logic [6:0] col_addr_d;
  logic [2:0] page_addr_d;
  logic ram_we;

  // only data bytes reach display memory
  assign ram_we = byte_vld_q && is_data_q;

  always_comb
  begin
    state_d = state_q;
    pend_d = pend_q;
    display_on_d = display_on_q;
    entire_on_d = entire_on_q;
    invert_d = invert_q;
    seg_remap_d = seg_remap_q;
    com_scan_rev_d = com_scan_rev_q;
    start_line_d = start_line_q;
    contrast_d = contrast_q;
    mux_ratio_d = mux_ratio_q;
    disp_offset_d = disp_offset_q;
    addr_mode_d = addr_mode_q;
    clk_div_d = clk_div_q;
    precharge_d = precharge_q;
    com_cfg_d = com_cfg_q;
    vcomh_d = vcomh_q;
    pump_cfg_d = pump_cfg_q;
    col_addr_d = col_addr_q;
    page_addr_d = page_addr_q;
    if (ram_we)
    begin
      // Pointer advance follows the addressing mode
      case (addr_mode_q)
        OIS_MODE_VERT:
        begin
          page_addr_d = page_addr_q + 3'h1;
          if (page_addr_q == OIS_PAGE_LAST)
          begin
            col_addr_d = col_addr_q + 7'h01;
          end
        end
        OIS_MODE_HORZ:
        begin
          col_addr_d = col_addr_q + 7'h01;
          if (col_addr_q == OIS_COL_LAST)
          begin
            page_addr_d = page_addr_q + 3'h1;
          end
        end
        default:
        begin
          // Page mode wraps within the page and never moves the page
          col_addr_d = col_addr_q + 7'h01;
        end
      endcase
    end
    else if (byte_vld_q)
    begin
      case (state_q)
        OIS_ST_PARAM:
        begin
          state_d = OIS_ST_CMD;
          case (pend_q)
            OIS_CMD_ADDR_MODE: addr_mode_d = byte_q[1:0];
            OIS_CMD_CONTRAST: contrast_d = byte_q;
            OIS_CMD_MUX: mux_ratio_d = byte_q[5:0];
            OIS_CMD_OFFSET: disp_offset_d = byte_q[5:0];
            OIS_CMD_CLK_DIV: clk_div_d = byte_q;
            OIS_CMD_PRECHG: precharge_d = byte_q;
            OIS_CMD_COM_CFG: com_cfg_d = byte_q;
            OIS_CMD_VCOMH: vcomh_d = byte_q;
            OIS_CMD_PUMP: pump_cfg_d = byte_q;
            default: pend_d = pend_q;
          endcase
        end
        default:
        begin
          if (ois_has_param(byte_q))
          begin
            state_d = OIS_ST_PARAM;
            pend_d = byte_q;
          end
          else if (byte_q[7:6] == OIS_GRP_START_LINE)
          begin
            start_line_d = byte_q[5:0];
          end
          else if (byte_q[7:4] == OIS_GRP_COL_LO)
          begin
            col_addr_d = {col_addr_q[6:4], byte_q[3:0]};
          end
          else if (byte_q[7:4] == OIS_GRP_COL_HI)
          begin
            col_addr_d = {byte_q[2:0], col_addr_q[3:0]};
          end
          else if (byte_q[7:3] == OIS_GRP_PAGE)
          begin
            page_addr_d = byte_q[2:0];
          end
          else
          begin
            case (byte_q)
              OIS_CMD_DISP_OFF: display_on_d = 1'b0;
              OIS_CMD_DISP_ON: display_on_d = 1'b1;
              OIS_CMD_SHOW_RAM: entire_on_d = 1'b0;
              OIS_CMD_ALL_ON: entire_on_d = 1'b1;
              OIS_CMD_POL_NORM: invert_d = 1'b0;
              OIS_CMD_POL_INV: invert_d = 1'b1;
              OIS_CMD_SEG_NORM: seg_remap_d = 1'b0;
              OIS_CMD_SEG_REMAP: seg_remap_d = 1'b1;
              OIS_CMD_SCAN_NORM: com_scan_rev_d = 1'b0;
              OIS_CMD_SCAN_REV: com_scan_rev_d = 1'b1;
              // Unknown commands are ignored
              default: state_d = OIS_ST_CMD;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= OIS_ST_CMD;
      pend_q <= '0;
      display_on_q <= 1'b0;
      mux_ratio_q <= OIS_MUX_RST;
      entire_on_q <= 1'b0;
      invert_q <= 1'b0;
      seg_remap_q <= 1'b0;
      com_scan_rev_q <= 1'b0;
      start_line_q <= OIS_START_RST;
      contrast_q <= OIS_CONTRAST_RST;
      disp_offset_q <= OIS_OFFSET_RST;
      addr_mode_q <= OIS_MODE_RST;
      clk_div_q <= OIS_CLK_DIV_RST;
      precharge_q <= OIS_PRECHG_RST;
      com_cfg_q <= OIS_COM_CFG_RST;
      vcomh_q <= OIS_VCOMH_RST;
      pump_cfg_q <= OIS_PUMP_RST;
      col_addr_q <= OIS_COL_RST;
      page_addr_q <= OIS_PAGE_RST;
    end
    else
    begin
      state_q <= state_d;
      pend_q <= pend_d;
      display_on_q <= display_on_d;
      mux_ratio_q <= mux_ratio_d;
      entire_on_q <= entire_on_d;
      invert_q <= invert_d;
      seg_remap_q <= seg_remap_d;
      com_scan_rev_q <= com_scan_rev_d;
      start_line_q <= start_line_d;
      contrast_q <= contrast_d;
      disp_offset_q <= disp_offset_d;
      addr_mode_q <= addr_mode_d;
      clk_div_q <= clk_div_d;
      precharge_q <= precharge_d;
      com_cfg_q <= com_cfg_d;
      vcomh_q <= vcomh_d;
      pump_cfg_q <= pump_cfg_d;
      col_addr_q <= col_addr_d;
      page_addr_q <= page_addr_d;
    end
  end

  ois_frame_ram u_ram (
    .ref_clk(ref_clk),
    .wr_en(ram_we),
    .wr_addr({page_addr_q, col_addr_q}),
    .wr_data(byte_q),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );
endmodule
`default_nettype wire

// file: test/ois_checker_sva.sv
`default_nettype none
module ois_checker_sva
  import ois_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic display_on_q,
  input wire logic entire_on_q,
  input wire logic seg_remap_q,
  input wire logic com_scan_rev_q,
  input wire logic [5:0] start_line_q,
  input wire logic [7:0] contrast_q,
  input wire logic [5:0] mux_ratio_q,
  input wire logic [6:0] col_addr_q
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_rst_disp_off: assert property ($rose(rst_n) |-> !display_on_q && mux_ratio_q == 6'h3F)
    else $error("display not off in 64 row mode after reset");
  a_rst_seg_map: assert property ($rose(rst_n) |-> !seg_remap_q)
    else $error("segment mapping not normal after reset");
  a_rst_start_line: assert property ($rose(rst_n) |-> start_line_q == 6'h00)
    else $error("start line not zero after reset");
  a_rst_col_addr: assert property ($rose(rst_n) |-> col_addr_q == 7'h00)
    else $error("column counter not zero after reset");
  a_rst_com_scan: assert property ($rose(rst_n) |-> !com_scan_rev_q)
    else $error("common scan not normal after reset");
  a_rst_contrast: assert property ($rose(rst_n) |-> contrast_q == 8'h7F)
    else $error("contrast not 7F after reset");
  a_rst_show_ram: assert property ($rose(rst_n) |-> !entire_on_q)
    else $error("entire display forced after reset");
  // Display on, contrast and column may not change unless a whole byte arrived inside a frame
  a_idle_hold: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3) |->
    $stable(display_on_q) && $stable(contrast_q) && $stable(col_addr_q))
    else $error("state changed with no framed byte");
endmodule

bind ois_sequencer ois_checker_sva ois_checker_sva_i (.ref_clk, .rst_n, .cs_n, .display_on_q,
  .entire_on_q, .seg_remap_q, .com_scan_rev_q, .start_line_q, .contrast_q, .mux_ratio_q,
  .col_addr_q);
`default_nettype wire

// file: test/ois_host_model.sv
`default_nettype none
module ois_host_model
  import ois_pkg::*;
(
  input wire logic ref_clk,
  output logic cs_n,
  output logic sclk,
  output logic serial_data_in,
  output logic dc_select_line
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    serial_data_in = 1'b0;
    dc_select_line = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic send_bits(input logic dc, input logic [7:0] b, input int n, input int half);
    wait_cyc(1);
    cs_n = 1'b0;
    dc_select_line = dc;
    for (int i = 7; i > 7 - n; i--)
    begin
      serial_data_in = b[i];
      wait_cyc(half);
      sclk = 1'b1;
      wait_cyc(half);
      sclk = 1'b0;
    end
    wait_cyc(half);
    // Released lines flip so a stale level never looks valid
    serial_data_in = ~serial_data_in;
    dc_select_line = ~dc;
    cs_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: test/ois_sequencer_test.sv
`default_nettype none
module ois_sequencer_test
  import ois_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, sclk, serial_data_in, dc_select_line;
  logic [OIS_RAM_AW-1:0] rd_addr = 10'h000;
  logic [7:0] rd_data, contrast_q, clk_div_q, precharge_q, com_cfg_q, vcomh_q, pump_cfg_q;
  logic display_on_q, entire_on_q, invert_q, seg_remap_q, com_scan_rev_q;
  logic [5:0] start_line_q, mux_ratio_q, disp_offset_q;
  logic [1:0] addr_mode_q;
  logic [6:0] col_addr_q;
  logic [2:0] page_addr_q;
  int n_errors = 0;
  int n_checks = 0;

  always #10 ref_clk = ~ref_clk;

  ois_host_model ois_host_model_i (.ref_clk, .cs_n, .sclk, .serial_data_in, .dc_select_line);
  ois_sequencer ois_sequencer_i (.ref_clk, .rst_n, .cs_n, .sclk, .serial_data_in,
    .dc_select_line, .rd_addr, .rd_data, .display_on_q, .entire_on_q, .invert_q, .seg_remap_q,
    .com_scan_rev_q, .start_line_q, .contrast_q, .mux_ratio_q, .disp_offset_q, .addr_mode_q,
    .clk_div_q, .precharge_q, .com_cfg_q, .vcomh_q, .pump_cfg_q, .col_addr_q, .page_addr_q);

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic tx(input logic dc, input logic [7:0] b);
    ois_host_model_i.send_bits(dc, b, 8, 2);
  endtask

  task automatic do_reset(input int n);
    rst_n = 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic t_reset_values();
    chk("display_on", 8'(display_on_q), 8'h00);
    chk("mux_ratio", 8'(mux_ratio_q), 8'h3F);
    chk("seg_remap", 8'(seg_remap_q), 8'h00);
    chk("start_line", 8'(start_line_q), 8'h00);
    chk("col_addr", 8'(col_addr_q), 8'h00);
    chk("com_scan", 8'(com_scan_rev_q), 8'h00);
    chk("contrast", contrast_q, 8'h7F);
    chk("entire_on", 8'(entire_on_q), 8'h00);
  endtask

  task automatic t_power_up();
    logic [7:0] seq [] = '{8'hAE, 8'h45, 8'h81, 8'hCF, 8'h20, 8'h02, 8'hA1, 8'hA4, 8'hA6,
      8'hA8, 8'h3F, 8'hC8, 8'hD3, 8'h00, 8'hD5, 8'h80, 8'hD9, 8'hF1, 8'hDA, 8'h12, 8'hDB,
      8'h30, 8'h8D, 8'h14};
    foreach (seq[i]) tx(1'b0, seq[i]);
    chk("vcomh", vcomh_q, 8'h30);
    chk("start_line", 8'(start_line_q), 8'h05);
    chk("contrast", contrast_q, 8'hCF);
    chk("seg_remap", 8'(seg_remap_q), 8'h01);
    chk("com_scan", 8'(com_scan_rev_q), 8'h01);
    chk("mux_ratio", 8'(mux_ratio_q), 8'h3F);
    chk("disp_offset", 8'(disp_offset_q), 8'h00);
    chk("precharge", precharge_q, 8'hF1);
    chk("pump_cfg", pump_cfg_q, 8'h14);
    chk("clk_div", clk_div_q, 8'h80);
    chk("com_cfg", com_cfg_q, 8'h12);
    chk("addr_mode", 8'(addr_mode_q), 8'h02);
    // Data byte that looks like a command must land in memory
    tx(1'b1, 8'hAF);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("display_on", 8'(display_on_q), 8'h00);
    chk("col_addr", 8'(col_addr_q), 8'h01);
    chk("rd_data", rd_data, 8'hAF);
    // Supply settle wait is host-side only, so it is skipped here
    tx(1'b0, 8'hAF);
    chk("display_on", 8'(display_on_q), 8'h01);
  endtask

  task automatic t_cmds();
    tx(1'b0, 8'hA5);
    chk("entire_on", 8'(entire_on_q), 8'h01);
    tx(1'b0, 8'hA4);
    chk("entire_on", 8'(entire_on_q), 8'h00);
    tx(1'b0, 8'hA7);
    chk("invert", 8'(invert_q), 8'h01);
    tx(1'b0, 8'hA6);
    chk("invert", 8'(invert_q), 8'h00);
    tx(1'b0, 8'hD5);
    tx(1'b0, 8'hF0);
    chk("clk_div", clk_div_q, 8'hF0);
    tx(1'b0, 8'hD3);
    tx(1'b0, 8'h07);
    chk("disp_offset", 8'(disp_offset_q), 8'h07);
    tx(1'b0, 8'hA8);
    tx(1'b0, 8'h1F);
    chk("mux_ratio", 8'(mux_ratio_q), 8'h1F);
    tx(1'b0, 8'hDA);
    tx(1'b0, 8'h02);
    chk("com_cfg", com_cfg_q, 8'h02);
    tx(1'b0, 8'h20);
    tx(1'b0, 8'h00);
    chk("addr_mode", 8'(addr_mode_q), 8'h00);
    tx(1'b0, 8'h20);
    tx(1'b0, 8'h02);
    chk("addr_mode", 8'(addr_mode_q), 8'h02);
    tx(1'b0, 8'hAE);
    chk("display_on", 8'(display_on_q), 8'h00);
    tx(1'b0, 8'hAF);
    tx(1'b0, 8'hA5);
  endtask

  task automatic t_addr();
    // Page mode: explicit page and column, then one data byte
    tx(1'b0, 8'hB3);
    tx(1'b0, 8'h05);
    tx(1'b0, 8'h12);
    chk("page_addr", 8'(page_addr_q), 8'h03);
    chk("col_addr", 8'(col_addr_q), 8'h25);
    rd_addr = {3'h3, 7'h25};
    tx(1'b1, 8'h5A);
    chk("col_addr", 8'(col_addr_q), 8'h26);
    chk("page_addr", 8'(page_addr_q), 8'h03);
    chk("rd_data", rd_data, 8'h5A);
    // Horizontal mode moves to the next page on column wrap
    tx(1'b0, 8'h20);
    tx(1'b0, 8'h00);
    tx(1'b0, 8'h0F);
    tx(1'b0, 8'h17);
    chk("col_addr", 8'(col_addr_q), 8'h7F);
    tx(1'b1, 8'h11);
    chk("col_addr", 8'(col_addr_q), 8'h00);
    chk("page_addr", 8'(page_addr_q), 8'h04);
    // Vertical mode moves the column on page wrap
    tx(1'b0, 8'h20);
    tx(1'b0, 8'h01);
    tx(1'b0, 8'hB7);
    tx(1'b1, 8'h22);
    chk("page_addr", 8'(page_addr_q), 8'h00);
    chk("col_addr", 8'(col_addr_q), 8'h01);
    // Page mode wraps the column and keeps the page
    tx(1'b0, 8'h20);
    tx(1'b0, 8'h02);
    tx(1'b0, 8'h0F);
    tx(1'b0, 8'h17);
    rd_addr = {3'h0, 7'h7F};
    tx(1'b1, 8'h33);
    chk("col_addr", 8'(col_addr_q), 8'h00);
    chk("page_addr", 8'(page_addr_q), 8'h00);
    chk("rd_data", rd_data, 8'h33);
  endtask

  task automatic t_abort();
    ois_host_model_i.send_bits(1'b0, 8'hAE, 4, 3);
    tx(1'b0, 8'hA7);
    chk("invert", 8'(invert_q), 8'h01);
    chk("display_on", 8'(display_on_q), 8'h01);
    ois_host_model_i.send_bits(1'b0, 8'hAE, 5, 3);
    // reset inside a frame; stale bits would complete AFh
    fork
      ois_host_model_i.send_bits(1'b0, 8'hAF, 8, 3);
      begin
        repeat (25) @(posedge ref_clk);
        #1;
        do_reset(2);
      end
    join
    chk("display_on", 8'(display_on_q), 8'h00);
    t_reset_values();
    tx(1'b0, 8'hA5);
    chk("entire_on", 8'(entire_on_q), 8'h01);
  endtask

  task automatic t_power_down();
    tx(1'b0, 8'hAF);
    chk("display_on", 8'(display_on_q), 8'h01);
    // Display off goes first; supply steps are host-side only
    tx(1'b0, 8'hAE);
    chk("display_on", 8'(display_on_q), 8'h00);
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    final_report();
  end

  initial
  begin
    do_reset(16);
    t_reset_values();
    t_power_up();
    t_cmds();
    t_addr();
    t_abort();
    t_power_down();
    final_report();
  end
endmodule
`default_nettype wire
